// ### design/ifb_bank.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Behaviour
// - A flag bit reads 1 once its source raised a request and 0 while none has occurred.
// - An enable bit at 1 passes its source's request on to the pending outputs, at 0 it blocks it there; event_status takes group 2..4 requests regardless.
// - Unimplemented bits of flag and enable registers read zero and ignore writes.
// - Implemented flag and enable bits are software read/write and reset to zero.
// - Flag group 2 holds DMA4 at 14, PMP at 13, DMA3/CAN/CAN-rx/SPI2/SPI2-err at 4..0.
// - Flag group 3 holds PWM1 fault A, RTC, DMA5, codec event, codec error, QEI1, PWM1 at 15..9.
// - Flag group 4 holds DAC left 15, DAC right 14, QEI2 11, PWM2 fault A 10, PWM2 error 9.
// - Flag group 4 holds CAN tx, DMA7, DMA6, CRC, UART2 error, UART1 error at 6..1.
// - Enable group 0 leaves bit 15 empty and holds DMA1 down to timer 3 at 14..8.
// - Enable group 0 holds timer 2 down to external interrupt 0 at 7..0.

module ifb_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire ifb_pkg::ifb_bus_req_t bus,
  output logic [15:0] rdata,
  // Peripheral request pulses, one vector per flag group
  input wire ifb_pkg::ifb_group_word_t src_req,
  // Flags of group 0 and enables of groups 2..4 held outside this bank
  input wire logic [15:0] ext_flags_group0,
  input wire ifb_pkg::ifb_group_word_t ext_enables,
  // Pending requests toward the priority logic
  output logic [15:0] pending_group0,
  output ifb_pkg::ifb_group_word_t pending,
  // Summary interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  // Implemented-bit mask of a mapped register; zero for anything else.
  function automatic logic [15:0] impl_mask(input logic [3:0] a);
    case (a)
      ifb_pkg::OFF_FLAGS_GROUP2: impl_mask = ifb_pkg::MASK_FLAGS_GROUP2;
      ifb_pkg::OFF_FLAGS_GROUP3: impl_mask = ifb_pkg::MASK_FLAGS_GROUP3;
      ifb_pkg::OFF_FLAGS_GROUP4: impl_mask = ifb_pkg::MASK_FLAGS_GROUP4;
      ifb_pkg::OFF_ENABLES_GROUP0: impl_mask = ifb_pkg::MASK_ENABLES_GROUP0;
      ifb_pkg::OFF_EVENT_STATUS: impl_mask = {13'h0000, ifb_pkg::MASK_EVENT};
      ifb_pkg::OFF_EVENT_MASK: impl_mask = {13'h0000, ifb_pkg::MASK_EVENT};
      default: impl_mask = 16'h0000;
    endcase
  endfunction : impl_mask

  logic [15:0] flags [3];
  logic [15:0] enables_group0;
  logic [2:0] event_status;
  logic [2:0] event_mask;

  wire [15:0] grp_mask [3];
  wire [15:0] grp_src [3];
  wire [15:0] grp_en [3];
  wire [3:0] grp_off [3];
  wire [15:0] wr_data_masked;
  wire wr_enables;
  wire wr_status;
  wire wr_mask;
  wire [2:0] grp_event;
  wire [15:0] read_mux;

  assign grp_mask[0] = ifb_pkg::MASK_FLAGS_GROUP2;
  assign grp_mask[1] = ifb_pkg::MASK_FLAGS_GROUP3;
  assign grp_mask[2] = ifb_pkg::MASK_FLAGS_GROUP4;
  assign grp_src[0] = src_req.group2;
  assign grp_src[1] = src_req.group3;
  assign grp_src[2] = src_req.group4;
  assign grp_en[0] = ext_enables.group2;
  assign grp_en[1] = ext_enables.group3;
  assign grp_en[2] = ext_enables.group4;
  assign grp_off[0] = ifb_pkg::OFF_FLAGS_GROUP2;
  assign grp_off[1] = ifb_pkg::OFF_FLAGS_GROUP3;
  assign grp_off[2] = ifb_pkg::OFF_FLAGS_GROUP4;

  // Unmapped and unimplemented bits are dropped here.
  // masking writes
  assign wr_data_masked = bus.wdata & impl_mask(bus.addr);
  assign wr_enables = bus.wr && (bus.addr == ifb_pkg::OFF_ENABLES_GROUP0);
  assign wr_status = bus.wr && (bus.addr == ifb_pkg::OFF_EVENT_STATUS);
  assign wr_mask = bus.wr && (bus.addr == ifb_pkg::OFF_EVENT_MASK);

  // ---------------------------------------------------------------
  // Flag groups
  // ---------------------------------------------------------------
  // A hardware request in the same cycle as a software write of 0 still
  // lands: losing it would silently drop an interrupt.
  for (genvar g = 0; g < 3; g++) begin : g_flags
    wire wr_hit;
    wire [15:0] hw_set;
    wire [15:0] next_flags;
    assign wr_hit = bus.wr && (bus.addr == grp_off[g]);
    assign hw_set = grp_src[g] & grp_mask[g];
    assign next_flags = (wr_hit ? wr_data_masked : flags[g]) | hw_set;
    assign grp_event[g] = |hw_set;
    assign pending[16*(2-g) +: 16] = flags[g] & grp_en[g] & grp_mask[g];

    always_ff @(posedge clock) begin
      if (!rstn) begin
        flags[g] <= ifb_pkg::RST_FLAGS;
      end else begin
        flags[g] <= next_flags;
      end
    end
  end

  // ---------------------------------------------------------------
  // Enable register group 0
  // ---------------------------------------------------------------
  // bits 14..0 stored
  always_ff @(posedge clock) begin
    if (!rstn) begin
      enables_group0 <= ifb_pkg::RST_ENABLES;
    end else if (wr_enables) begin
      enables_group0 <= wr_data_masked;
    end
  end

  assign pending_group0 = ext_flags_group0 & enables_group0;

  // ---------------------------------------------------------------
  // Event summary and interrupt
  // ---------------------------------------------------------------
  wire [2:0] next_status;
  assign next_status = (event_status & ~(wr_status ? wr_data_masked[2:0] : 3'h0)) | grp_event;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      event_status <= ifb_pkg::RST_EVENT;
      event_mask <= ifb_pkg::RST_EVENT;
    end else begin
      event_status <= next_status;
      if (wr_mask) begin
        event_mask <= wr_data_masked[2:0];
      end
    end
  end

  assign irq = |(event_status & event_mask);

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // unimplemented bits read zero
  assign read_mux = impl_mask(bus.addr) & (
      (bus.addr == ifb_pkg::OFF_FLAGS_GROUP2) ? flags[0] :
      (bus.addr == ifb_pkg::OFF_FLAGS_GROUP3) ? flags[1] :
      (bus.addr == ifb_pkg::OFF_FLAGS_GROUP4) ? flags[2] :
      (bus.addr == ifb_pkg::OFF_ENABLES_GROUP0) ? enables_group0 :
      (bus.addr == ifb_pkg::OFF_EVENT_STATUS) ? {13'h0000, event_status} :
      (bus.addr == ifb_pkg::OFF_EVENT_MASK) ? {13'h0000, event_mask} : 16'h0000);

  // Read data stands in the cycle after each cycle with bus.rd high and is zero otherwise.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= bus.rd ? read_mux : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_read_g2;
    bus.rd && bus.addr == ifb_pkg::OFF_FLAGS_GROUP2;
  endsequence

  sequence s_write_en_zero;
    wr_enables && bus.wdata == 16'h0000;
  endsequence

  flag_set_a: assert property (src_req.group2[ifb_pkg::BIT_DMA_CH4_DONE_FLAG]
      |=> flags[0][ifb_pkg::BIT_DMA_CH4_DONE_FLAG])
    else $error("group 2 request did not latch");

  set_wins_a: assert property (bus.wr && bus.addr == ifb_pkg::OFF_FLAGS_GROUP4
      && src_req.group4[ifb_pkg::BIT_CAN_TX_READY_FLAG]
      |=> flags[2][ifb_pkg::BIT_CAN_TX_READY_FLAG])
    else $error("request lost against a clearing write");

  enable_block_a: assert property (s_write_en_zero |=> pending_group0 == 16'h0000)
    else $error("request passed with enables cleared");

  read_zero_a: assert property (s_read_g2 |=> (rdata & ~ifb_pkg::MASK_FLAGS_GROUP2) == 16'h0000
      ##0 rdata == $past(flags[0]))
    else $error("group 2 read wrong");

  enable_bit15_a: assert property (wr_enables && bus.wdata[15]
      |=> !enables_group0[15])
    else $error("enable bit 15 stored");

  reset_zero_a: assert property (@(posedge clock) disable iff (1'b0)
      !rstn |=> flags[1] == 16'h0000 && enables_group0 == 16'h0000 && rdata == 16'h0000)
    else $error("not cleared by reset");

  group3_bits_a: assert property ((flags[1] & ~ifb_pkg::MASK_FLAGS_GROUP3) == 16'h0000)
    else $error("group 3 low bits set");

  group4_bits_a: assert property ((flags[2] & ~ifb_pkg::MASK_FLAGS_GROUP4) == 16'h0000)
    else $error("group 4 unimplemented bits set");

  group2_bits_a: assert property ((flags[0] & ~ifb_pkg::MASK_FLAGS_GROUP2) == 16'h0000)
    else $error("group 2 unimplemented bits set");

  sw_raise_a: assert property (bus.wr && bus.addr == ifb_pkg::OFF_FLAGS_GROUP3
      && bus.wdata[ifb_pkg::BIT_PWM1_FAULT_A_FLAG] && ext_enables.group3[15]
      |=> ##0 flags[1][15] ##0 (pending.group3[15] == ext_enables.group3[15]))
    else $error("software raise not pending");

  enable_low_a: assert property (bus.wr && bus.addr == ifb_pkg::OFF_ENABLES_GROUP0
      |=> enables_group0[ifb_pkg::BIT_EXTERNAL_IRQ0_ENABLE]
          == $past(bus.wdata[ifb_pkg::BIT_EXTERNAL_IRQ0_ENABLE]))
    else $error("enable bit 0 not written");

  group4_low_a: assert property (src_req.group4[1] |=> flags[2][1] ##1 flags[2][1]
      || $past(bus.wr && bus.addr == ifb_pkg::OFF_FLAGS_GROUP4))
    else $error("uart1 error flag not sticky");

  // ---------------------------------------------------------------
  // Checks on placement, storage and gating
  // ---------------------------------------------------------------
  // Stores are judged only when no request hits the same register in that
  // cycle, since a request would rightly override the written value.
  sequence s_read_g3;
    bus.rd && bus.addr == ifb_pkg::OFF_FLAGS_GROUP3;
  endsequence

  sequence s_read_g4;
    bus.rd && bus.addr == ifb_pkg::OFF_FLAGS_GROUP4;
  endsequence

  sequence s_read_en;
    bus.rd && bus.addr == ifb_pkg::OFF_ENABLES_GROUP0;
  endsequence

  sequence s_plain_write_g3;
    bus.wr && bus.addr == ifb_pkg::OFF_FLAGS_GROUP3 && src_req.group3 == 16'h0000;
  endsequence

  sequence s_clear_g2;
    bus.wr && bus.addr == ifb_pkg::OFF_FLAGS_GROUP2 && bus.wdata == 16'h0000
        && src_req.group2 == 16'h0000;
  endsequence

  read_g3_a: assert property (s_read_g3 |=> rdata == $past(flags[1]))
    else $error("group 3 read wrong");

  read_g4_a: assert property (s_read_g4 |=> rdata == $past(flags[2]))
    else $error("group 4 read wrong");

  read_en_a: assert property (s_read_en |=> rdata == $past(enables_group0))
    else $error("enable read wrong");

  read_idle_a: assert property (!bus.rd |=> rdata == 16'h0000)
    else $error("read data without a read");

  write_store_a: assert property (s_plain_write_g3
      |=> flags[1] == ($past(bus.wdata) & ifb_pkg::MASK_FLAGS_GROUP3))
    else $error("group 3 write not stored");

  en_store_a: assert property (wr_enables
      |=> enables_group0 == ($past(bus.wdata) & ifb_pkg::MASK_ENABLES_GROUP0))
    else $error("enable write not stored");

  flag_clear_a: assert property (s_clear_g2 |=> flags[0] == 16'h0000)
    else $error("group 2 flags not cleared");

  dma3_pos_a: assert property (src_req.group2[ifb_pkg::BIT_DMA_CH3_DONE_FLAG]
      |=> flags[0][4])
    else $error("channel 3 flag misplaced");

  pmp_pos_a: assert property (src_req.group2[13]
      |=> flags[0][ifb_pkg::BIT_PARALLEL_MASTER_PORT_FLAG])
    else $error("port flag misplaced");

  fault1_pos_a: assert property (src_req.group3[ifb_pkg::BIT_PWM1_FAULT_A_FLAG]
      |=> flags[1][15])
    else $error("fault flag misplaced");

  dac_pos_a: assert property (src_req.group4[ifb_pkg::BIT_DAC_LEFT_FLAG]
      |=> flags[2][15])
    else $error("dac flag misplaced");

  can_tx_pos_a: assert property (src_req.group4[ifb_pkg::BIT_CAN_TX_READY_FLAG]
      |=> flags[2][6])
    else $error("transmit flag misplaced");

  pend_block_a: assert property (!ext_enables.group2[ifb_pkg::BIT_DMA_CH4_DONE_FLAG]
      |-> !pending.group2[14])
    else $error("blocked request pending");

  pend_pass_a: assert property (flags[0][14] && ext_enables.group2[14]
      |-> pending.group2[ifb_pkg::BIT_DMA_CH4_DONE_FLAG])
    else $error("enabled flag not pending");

  g0_block_a: assert property (!enables_group0[ifb_pkg::BIT_EXTERNAL_IRQ0_ENABLE]
      |-> !pending_group0[0])
    else $error("group 0 blocked request pending");

  irq_masked_a: assert property (event_mask == 3'h0 |-> !irq)
    else $error("interrupt with all events masked");

endmodule : ifb_bank

// ### design/ifb_pkg.sv
package ifb_pkg;

  // ---------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFF_FLAGS_GROUP2 = 4'h0;
  localparam logic [3:0] OFF_FLAGS_GROUP3 = 4'h1;
  localparam logic [3:0] OFF_FLAGS_GROUP4 = 4'h2;
  localparam logic [3:0] OFF_ENABLES_GROUP0 = 4'h3;
  localparam logic [3:0] OFF_EVENT_STATUS = 4'h4;
  localparam logic [3:0] OFF_EVENT_MASK = 4'h5;

  // ---------------------------------------------------------------
  // Implemented bit masks
  // ---------------------------------------------------------------
  // Group 2: bits 14,13 and 4..0.
  localparam logic [15:0] MASK_FLAGS_GROUP2 = 16'h601F;
  // Group 3: bits 15..9.
  localparam logic [15:0] MASK_FLAGS_GROUP3 = 16'hFE00;
  // Group 4: bits 15,14, 11..9 and 6..1.
  localparam logic [15:0] MASK_FLAGS_GROUP4 = 16'hCE7E;
  // Enables group 0: bits 14..0.
  localparam logic [15:0] MASK_ENABLES_GROUP0 = 16'h7FFF;
  localparam logic [2:0] MASK_EVENT = 3'h7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_ENABLES = 16'h0000;
  localparam logic [2:0] RST_EVENT = 3'h0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_DMA_CH4_DONE_FLAG = 14;
  localparam int BIT_PARALLEL_MASTER_PORT_FLAG = 13;
  localparam int BIT_DMA_CH3_DONE_FLAG = 4;
  localparam int BIT_PWM1_FAULT_A_FLAG = 15;
  localparam int BIT_DAC_LEFT_FLAG = 15;
  localparam int BIT_CAN_TX_READY_FLAG = 6;
  localparam int BIT_DMA_CH1_DONE_ENABLE = 14;
  localparam int BIT_EXTERNAL_IRQ0_ENABLE = 0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ifb_bus_req_t;

  typedef struct packed {
    logic [15:0] group2;
    logic [15:0] group3;
    logic [15:0] group4;
  } ifb_group_word_t;

endpackage : ifb_pkg

// ### dv/ifb_source_model.sv
`timescale 1ns/100ps
module ifb_source_model (
  // Clock
  input wire logic clock,
  // Lines toward the bank
  output ifb_pkg::ifb_group_word_t src_req,
  output logic [15:0] ext_flags_group0,
  output ifb_pkg::ifb_group_word_t ext_enables
);
  initial begin
    src_req = '0;
    ext_flags_group0 = 16'h0000;
    ext_enables = '0;
  end

  // Requests are one-cycle pulses so a stuck source cannot mask a flag clear.
  task automatic pulse(input logic [47:0] w);
    @(posedge clock);
    src_req <= w;
    @(posedge clock);
    src_req <= '0;
  endtask : pulse

  task automatic set_side(input logic [15:0] f0, input logic [47:0] en);
    @(posedge clock);
    ext_flags_group0 <= f0;
    ext_enables <= en;
  endtask : set_side
endmodule : ifb_source_model

// ### dv/interrupt_flag_enable_bank_test.sv
`timescale 1ns/100ps
module interrupt_flag_enable_bank_test;
  logic clock;
  logic rstn;
  ifb_pkg::ifb_bus_req_t bus;
  logic [15:0] rdata;
  ifb_pkg::ifb_group_word_t src_req;
  logic [15:0] ext_flags_group0;
  ifb_pkg::ifb_group_word_t ext_enables;
  logic [15:0] pending_group0;
  ifb_pkg::ifb_group_word_t pending;
  logic irq;
  int bad_count;
  int comparisons;
  logic [15:0] impl [0:3];
  logic [3:0] offs [0:3];
  logic [47:0] v;
  logic [47:0] pv;
  logic [15:0] exp;

  ifb_bank u_dut (
    .clock(clock),
    .rstn(rstn),
    .bus(bus),
    .rdata(rdata),
    .src_req(src_req),
    .ext_flags_group0(ext_flags_group0),
    .ext_enables(ext_enables),
    .pending_group0(pending_group0),
    .pending(pending),
    .irq(irq)
  );

  ifb_source_model u_src (
    .clock(clock),
    .src_req(src_req),
    .ext_flags_group0(ext_flags_group0),
    .ext_enables(ext_enables)
  );

  // ---------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] want);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 check(rdata, want);
  endtask : rd

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    bad_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    bus = '0;
    impl = '{16'h601F, 16'hFE00, 16'hCE7E, 16'h7FFF};
    offs = '{ifb_pkg::OFF_FLAGS_GROUP2, ifb_pkg::OFF_FLAGS_GROUP3,
      ifb_pkg::OFF_FLAGS_GROUP4, ifb_pkg::OFF_ENABLES_GROUP0};
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(4'(k), 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(offs[k], 16'hFFFF);
      rd(offs[k], impl[k]);
      wr(offs[k], 16'h0000);
      rd(offs[k], 16'h0000);
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    // Walk a single request over every position of each flag group.
    u_src.set_side(16'hFFFF, '1);
    for (int g = 0; g < 3; g++) begin
      for (int i = 0; i < 16; i++) begin
        v = 48'h0;
        v[32 - 16 * g + i] = 1'b1;
        exp = impl[g] & (16'h0001 << i);
        u_src.pulse(v);
        #1 pv = pending;
        check(pv[32 - 16 * g +: 16], exp);
        rd(offs[g], exp);
        wr(offs[g], 16'h0000);
      end
    end
    wr(ifb_pkg::OFF_ENABLES_GROUP0, 16'h0001);
    #1 check(pending_group0, 16'h0001);
    wr(ifb_pkg::OFF_ENABLES_GROUP0, 16'h4100);
    #1 check(pending_group0, 16'h4100);
    wr(ifb_pkg::OFF_ENABLES_GROUP0, 16'hFFFF);
    #1 check(pending_group0, 16'h7FFF);
    u_src.set_side(16'h0000, 48'h0);
    wr(ifb_pkg::OFF_FLAGS_GROUP3, 16'h8000);
    rd(ifb_pkg::OFF_FLAGS_GROUP3, 16'h8000);
    check(pending.group3, 16'h0000);
    u_src.set_side(16'h0000, {16'h0000, 16'hFFFF, 16'h0000});
    #1 check(pending.group3, 16'h8000);
    wr(ifb_pkg::OFF_FLAGS_GROUP3, 16'h0000);
    #1 check(pending.group3, 16'h0000);
    wr(ifb_pkg::OFF_FLAGS_GROUP3, 16'h8000);
    #1 check(pending.group3, 16'h8000);
    // Interrupt: raise, mask, unmask, clear.
    wr(ifb_pkg::OFF_EVENT_STATUS, 16'h0007);
    rd(ifb_pkg::OFF_EVENT_STATUS, 16'h0000);
    u_src.pulse(48'h2);
    rd(ifb_pkg::OFF_EVENT_STATUS, 16'h0004);
    check({15'h0000, irq}, 16'h0000);
    wr(ifb_pkg::OFF_EVENT_MASK, 16'h0004);
    #1 check({15'h0000, irq}, 16'h0001);
    rd(ifb_pkg::OFF_EVENT_MASK, 16'h0004);
    wr(ifb_pkg::OFF_EVENT_STATUS, 16'h0004);
    #1 check({15'h0000, irq}, 16'h0000);
    rd(ifb_pkg::OFF_FLAGS_GROUP4, 16'h0002);
    // A clearing write and a request in one cycle: the request must survive.
    fork
      u_src.pulse(48'h40);
      wr(ifb_pkg::OFF_FLAGS_GROUP4, 16'h0000);
    join
    rd(ifb_pkg::OFF_FLAGS_GROUP4, 16'h0040);
    end_sim();
  end
endmodule : interrupt_flag_enable_bank_test
